// ---- src/drive_status_indicator_logic.sv ----
/*
 Drive status indicators: network run and error lamps and a seven segment
 status display. Inputs arrive from other logic on CLK except the short-circuit
 and safety pin levels, which are synchronised here.
*/
`timescale 1ns/10ps
`include "status_ind_map.svh"
module drive_status_indicator_logic
#(
   parameter logic [31:0] BLINK_CYCLES = `BLINK_CYC,
   parameter logic [31:0] FLASH_ON_CYCLES = `FLASH_ON_CYC,
   parameter logic [31:0] FLASH_OFF_CYCLES = `FLASH_OFF_CYC,
   parameter logic [31:0] DIGIT_CYCLES = `DIGIT_CYC
)
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic STARTUP_DONE,
   input wire logic FW_LOADING,
   input wire logic [3:0] FW_STAGE,
   input wire status_ind_pkg::fb_state_t FB_STATE,
   input wire logic IDENTIFY_REQ,
   input wire status_ind_pkg::err_class_t FB_ERR_CLASS,
   input wire logic ERROR_ACTIVE,
   input wire logic [19:0] ERROR_CODE,
   input wire logic ERROR_IS_SAFE_TORQUE_CUT,
   input wire logic SAFE_TORQUE_CUT_A,
   input wire logic SAFE_TORQUE_CUT_B,
   input wire logic DRIVE_ENABLED,
   input wire logic SUSPEND_ACTIVE,
   input wire logic STOP_ACTIVE,
   input wire logic HOLD_TO_ANALOG,
   input wire status_ind_pkg::motion_t MOTION_TYPE,
   input wire logic USER_SYMBOL_WRITE,
   input wire status_ind_pkg::seg_t USER_SYMBOL,
   input wire logic USER_SYMBOL_CLEAR,
   input wire logic PHASE_SHORT,
   output logic NETWORK_RUN_LAMP,
   output logic NETWORK_ERROR_LAMP,
   output status_ind_pkg::seg_t SEGMENTS,
   output logic DECIMAL_POINT,
   output logic DEMAND_RAMP_ZERO,
   output logic DRIVE_TRIPPED
);
   import status_ind_pkg::*;

   function automatic seg_t bcd_to_seg(input bcd_t d);
      case (d)
         4'h0: bcd_to_seg = `SEG_O;
         4'h1: bcd_to_seg = `SEG_INC;
         4'h2: bcd_to_seg = `SEG_SPL;
         4'h3: bcd_to_seg = 7'h4F;
         4'h4: bcd_to_seg = 7'h66;
         4'h5: bcd_to_seg = `SEG_5;
         4'h6: bcd_to_seg = 7'h7D;
         4'h7: bcd_to_seg = `SEG_FOLLOW;
         4'h8: bcd_to_seg = `SEG_8;
         4'h9: bcd_to_seg = `SEG_TORQ;
         default: bcd_to_seg = `SEG_BLANK;
      endcase
   endfunction : bcd_to_seg

   function automatic seg_t motion_seg(input motion_t m);
      case (m)
         `MOT_CAM: motion_seg = `SEG_C;
         `MOT_DWELL: motion_seg = `SEG_D;
         `MOT_SHEAR: motion_seg = `SEG_F;
         `MOT_FOLLOW: motion_seg = `SEG_FOLLOW;
         `MOT_HOME: motion_seg = `SEG_HOME;
         `MOT_INC: motion_seg = `SEG_INC;
         `MOT_JOG: motion_seg = `SEG_J;
         `MOT_OFFSET: motion_seg = `SEG_O;
         `MOT_POS: motion_seg = `SEG_P;
         `MOT_TORQUE: motion_seg = `SEG_TORQ;
         `MOT_VEL: motion_seg = `SEG_VEL;
         `MOT_SPLINE: motion_seg = `SEG_SPL;
         default: motion_seg = `SEG_8;
      endcase
   endfunction : motion_seg

   // Pin level synchronisers; first stage feeds only the second
   logic [2:0] pin_meta;
   logic [2:0] pin_sync;
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         pin_meta <= 3'h0;
         pin_sync <= 3'h0;
      end
      else
      begin
         pin_meta <= {PHASE_SHORT, SAFE_TORQUE_CUT_B, SAFE_TORQUE_CUT_A};
         pin_sync <= pin_meta;
      end
   end
   logic short_seen;
   logic cut_a;
   logic cut_b;
   assign short_seen = pin_sync[2];
   assign cut_a = pin_sync[0];
   assign cut_b = pin_sync[1];

   // Trip latch survives everything except the power-on reset
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         DRIVE_TRIPPED <= 1'b0;
      end
      else if (short_seen)
      begin
         DRIVE_TRIPPED <= 1'b1;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         DEMAND_RAMP_ZERO <= 1'b0;
      end
      else
      begin
         DEMAND_RAMP_ZERO <= SUSPEND_ACTIVE || DRIVE_TRIPPED;
      end
   end

   // Network lamp pattern selection
   lamp_pat_t run_pat;
   lamp_pat_t err_pat;
   always_comb
   begin
      run_pat = `PAT_OFF;
      err_pat = `PAT_OFF;
      if (STARTUP_DONE)
      begin
         if (IDENTIFY_REQ)
         begin
            run_pat = `PAT_FLASH3;
         end
         else if (FB_STATE == `FB_PREOP)
         begin
            run_pat = `PAT_BLINK;
         end
         else if (FB_STATE == `FB_SAFEOP)
         begin
            run_pat = `PAT_FLASH1;
         end
         else if (FB_STATE == `FB_OP)
         begin
            run_pat = `PAT_ON;
         end
         case (FB_ERR_CLASS)
            `ERRC_CONFIG: err_pat = `PAT_BLINK;
            `ERRC_LOCAL: err_pat = `PAT_FLASH1;
            `ERRC_WDOG: err_pat = `PAT_FLASH2;
            default: err_pat = `PAT_OFF;
         endcase
      end
   end

   lamp_pattern run_gen
   (
      .clk(CLK),
      .rst_n(RST_N),
      .pattern(run_pat),
      .blink_cyc(BLINK_CYCLES),
      .flash_on_cyc(FLASH_ON_CYCLES),
      .flash_off_cyc(FLASH_OFF_CYCLES),
      .lamp(NETWORK_RUN_LAMP)
   );

   lamp_pattern err_gen
   (
      .clk(CLK),
      .rst_n(RST_N),
      .pattern(err_pat),
      .blink_cyc(BLINK_CYCLES),
      .flash_on_cyc(FLASH_ON_CYCLES),
      .flash_off_cyc(FLASH_OFF_CYCLES),
      .lamp(NETWORK_ERROR_LAMP)
   );

   // User symbol holds until cleared; an error still overrides it
   logic user_valid;
   seg_t user_seg;
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         user_valid <= 1'b0;
         user_seg <= `SEG_BLANK;
      end
      else if (USER_SYMBOL_WRITE)
      begin
         user_valid <= 1'b1;
         user_seg <= USER_SYMBOL;
      end
      else if (USER_SYMBOL_CLEAR)
      begin
         user_valid <= 1'b0;
      end
   end

   // Display sequencer
   disp_state_t disp_state;
   logic [31:0] dwell;
   logic [2:0] pos;
   logic dwell_done;
   assign dwell_done = (dwell + 32'h1 >= DIGIT_CYCLES);

   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         disp_state <= DSP_FW_WALK;
         dwell <= 32'h0;
         pos <= 3'h0;
      end
      else
      begin
         dwell <= dwell_done ? 32'h0 : dwell + 32'h1;
         case (disp_state)
            DSP_FW_WALK:
            begin
               if (dwell_done)
               begin
                  pos <= (pos == `SEG_WALK_LAST) ? 3'h0 : pos + 3'h1;
               end
               if (!FW_LOADING)
               begin
                  disp_state <= DSP_FW_STAGE;
               end
            end
            DSP_FW_STAGE:
            begin
               if (STARTUP_DONE)
               begin
                  disp_state <= DSP_RUN;
               end
            end
            DSP_RUN:
            begin
               if (ERROR_ACTIVE)
               begin
                  disp_state <= DSP_ERROR;
                  pos <= 3'h0;
                  dwell <= 32'h0;
               end
            end
            DSP_ERROR:
            begin
               if (dwell_done)
               begin
                  pos <= (pos == `ERR_POS_LAST) ? 3'h0 : pos + 3'h1;
                  if (pos == `ERR_POS_LAST && !ERROR_ACTIVE)
                  begin
                     disp_state <= DSP_RUN;
                  end
               end
            end
            default: disp_state <= DSP_RUN;
         endcase
      end
   end

   // Error digit for the current sequence position, most significant first
   bcd_t err_digit;
   always_comb
   begin
      case (pos)
         3'h1: err_digit = bcd_t'(ERROR_CODE[19:16]);
         3'h2: err_digit = bcd_t'(ERROR_CODE[15:12]);
         3'h3: err_digit = bcd_t'(ERROR_CODE[11:8]);
         3'h4: err_digit = bcd_t'(ERROR_CODE[7:4]);
         default: err_digit = bcd_t'(ERROR_CODE[3:0]);
      endcase
   end

   seg_t next_segments;
   logic next_dp;
   always_comb
   begin
      next_dp = 1'b0;
      case (disp_state)
         DSP_FW_WALK: next_segments = seg_t'(`SEG_ONE << pos);
         DSP_FW_STAGE: next_segments = bcd_to_seg(FW_STAGE);
         DSP_ERROR:
         begin
            next_segments = (pos == 3'h0) ? `SEG_E : bcd_to_seg(err_digit);
            next_dp = ERROR_IS_SAFE_TORQUE_CUT;
         end
         default:
         begin
            if (user_valid)
            begin
               next_segments = user_seg;
            end
            else if (!DRIVE_ENABLED)
            begin
               next_segments = (cut_a && cut_b) ? `SEG_DASH : `SEG_DASH_CUT;
            end
            else if (SUSPEND_ACTIVE)
            begin
               next_segments = `SEG_UNDER;
            end
            else if (STOP_ACTIVE)
            begin
               next_segments = `SEG_5;
            end
            else if (HOLD_TO_ANALOG)
            begin
               next_segments = `SEG_HOLD;
            end
            else if (MOTION_TYPE == `MOT_NONE)
            begin
               next_segments = `SEG_8;
            end
            else
            begin
               next_segments = motion_seg(MOTION_TYPE);
            end
         end
      endcase
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         SEGMENTS <= `SEG_BLANK;
         DECIMAL_POINT <= 1'b0;
      end
      else
      begin
         SEGMENTS <= next_segments;
         DECIMAL_POINT <= next_dp;
      end
   end
endmodule : drive_status_indicator_logic

// ---- src/status_ind_map.svh ----
/*
 Timing counts, lamp pattern codes and display constants for the drive status
 indicator. Assumes a 25 MHz system clock and a single synchronous reset.
*/
// Operation
// - Run lamp off in initialisation state or when unpowered.
// - Run lamp blinks in pre-operational, single flash in safe-operational.
// - Run lamp triple flash for identification, requested by the remote master.
// - Run lamp steady on in operational state.
// - Error lamp off when no fieldbus error or unpowered.
// - Error lamp blinks on any invalid configuration error.
// - Error lamp single flash on local errors.
// - Error lamp double flash on watchdog and synchronisation faults.
// - Network lamp patterns shown only after startup sequence finished.
// - On error, display steps through letter E then five error-code digits.
// - Right decimal point lights while active error concerns safe torque cut.
// - Distinct disabled symbols with and without safety inputs powered.
// - Suspend shows underscore and ramps motion demand to zero.
// - Firmware loading lights segments in turn, then initialisation stage digits.
// - Digit eight shown when enabled but idle.
// - One distinct symbol per active motion type.
// - Digit five shown while stop command or stop input active.
// - Dedicated symbol while in hold-to-analog mode.
// - Software may write user-defined symbols to the display.
// - Motor phase short trips and latches until mains power removed.
`ifndef STATUS_IND_MAP_SVH
`define STATUS_IND_MAP_SVH

// Lamp and digit timing in ms and derived cycles at 25 MHz
`define CLK_KHZ 25000
`define BLINK_MS 200
`define FLASH_ON_MS 200
`define FLASH_OFF_MS 1000
`define BLINK_CYC (`BLINK_MS * `CLK_KHZ)
`define FLASH_ON_CYC (`FLASH_ON_MS * `CLK_KHZ)
`define FLASH_OFF_CYC (`FLASH_OFF_MS * `CLK_KHZ)
`define DIGIT_MS 500
`define DIGIT_CYC (`DIGIT_MS * `CLK_KHZ)

// Fieldbus slave states
`define FB_INIT 4'h1
`define FB_PREOP 4'h2
`define FB_BOOT 4'h3
`define FB_SAFEOP 4'h4
`define FB_OP 4'h8

// Error classes from the slave controller
`define ERRC_NONE 2'h0
`define ERRC_CONFIG 2'h1
`define ERRC_LOCAL 2'h2
`define ERRC_WDOG 2'h3

// Lamp pattern codes
`define PAT_OFF 3'h0
`define PAT_BLINK 3'h1
`define PAT_FLASH1 3'h2
`define PAT_FLASH2 3'h3
`define PAT_FLASH3 3'h4
`define PAT_ON 3'h5

// Error display sequence and segment walk
`define ERR_DIGITS 3'h5
`define ERR_POS_LAST 3'h5
`define SEG_WALK_LAST 3'h5

// Seven segment codes, bit order gfedcba
`define SEG_BLANK 7'h00
`define SEG_E 7'h79
`define SEG_DASH 7'h40
`define SEG_DASH_CUT 7'h48
`define SEG_UNDER 7'h08
`define SEG_HOLD 7'h77
`define SEG_8 7'h7F
`define SEG_5 7'h6D
`define SEG_C 7'h39
`define SEG_D 7'h5E
`define SEG_F 7'h71
`define SEG_FOLLOW 7'h07
`define SEG_HOME 7'h76
`define SEG_INC 7'h06
`define SEG_J 7'h1E
`define SEG_O 7'h3F
`define SEG_P 7'h73
`define SEG_TORQ 7'h67
`define SEG_VEL 7'h3E
`define SEG_SPL 7'h5B
`define SEG_ONE 7'h01

// Motion types
`define MOT_NONE 4'h0
`define MOT_CAM 4'h1
`define MOT_DWELL 4'h2
`define MOT_SHEAR 4'h3
`define MOT_FOLLOW 4'h4
`define MOT_HOME 4'h5
`define MOT_INC 4'h6
`define MOT_JOG 4'h7
`define MOT_OFFSET 4'h8
`define MOT_POS 4'h9
`define MOT_TORQUE 4'hA
`define MOT_VEL 4'hB
`define MOT_SPLINE 4'hC

`endif

// ---- src/status_ind_pkg.sv ----
/*
 Types shared by the drive status indicator files.
 Assumes status_ind_map.svh is compiled alongside for constants.
*/
package status_ind_pkg;
   typedef logic [2:0] lamp_pat_t;
   typedef logic [3:0] fb_state_t;
   typedef logic [1:0] err_class_t;
   typedef logic [3:0] motion_t;
   typedef logic [6:0] seg_t;
   typedef logic [3:0] bcd_t;
   typedef enum {DSP_FW_WALK, DSP_FW_STAGE, DSP_RUN, DSP_ERROR} disp_state_t;
endpackage : status_ind_pkg

// ---- src/lamp_pattern.sv ----
/*
 One indicator lamp pattern generator: off, blink, 1/2/3 flashes, steady on.
 Assumes on/off counts are stable and nonzero; pattern changes restart cleanly.
*/
`timescale 1ns/10ps
`include "status_ind_map.svh"
module lamp_pattern
(
   input wire logic clk,
   input wire logic rst_n,
   input wire status_ind_pkg::lamp_pat_t pattern,
   input wire logic [31:0] blink_cyc,
   input wire logic [31:0] flash_on_cyc,
   input wire logic [31:0] flash_off_cyc,
   output logic lamp
);
   import status_ind_pkg::*;
   lamp_pat_t last_pat;
   logic [31:0] count;
   logic [2:0] pulse;
   logic phase_on;
   logic [2:0] flashes;
   logic [31:0] period;

   always_comb
   begin
      flashes = 3'h1;
      if (pattern == `PAT_FLASH2)
      begin
         flashes = 3'h2;
      end
      else if (pattern == `PAT_FLASH3)
      begin
         flashes = 3'h3;
      end
      if (pattern == `PAT_BLINK)
      begin
         period = blink_cyc;
      end
      else if (phase_on)
      begin
         period = flash_on_cyc;
      end
      else if (pulse + 3'h1 < flashes)
      begin
         period = flash_on_cyc;
      end
      else
      begin
         period = flash_off_cyc;
      end
   end

   // Counter restarts on a pattern change so a new pattern begins with a full on phase
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         last_pat <= `PAT_OFF;
         count <= 32'h0;
         pulse <= 3'h0;
         phase_on <= 1'b1;
      end
      else if (pattern != last_pat)
      begin
         last_pat <= pattern;
         count <= 32'h0;
         pulse <= 3'h0;
         phase_on <= 1'b1;
      end
      else if (count + 32'h1 >= period)
      begin
         count <= 32'h0;
         phase_on <= !phase_on;
         if (!phase_on)
         begin
            pulse <= (pulse + 3'h1 >= flashes) ? 3'h0 : pulse + 3'h1;
         end
      end
      else
      begin
         count <= count + 32'h1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         lamp <= 1'b0;
      end
      else
      begin
         case (pattern)
            `PAT_OFF: lamp <= 1'b0;
            `PAT_ON: lamp <= 1'b1;
            default: lamp <= phase_on && (pattern == last_pat);
         endcase
      end
   end
endmodule : lamp_pattern

// ---- verification/drive_status_indicator_logic_assertions.sv ----
/*
 Port checker for the drive status indicator, bound to its top module.
 Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/10ps
`include "status_ind_map.svh"
module status_ind_checker
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic STARTUP_DONE,
   input wire status_ind_pkg::fb_state_t FB_STATE,
   input wire logic IDENTIFY_REQ,
   input wire status_ind_pkg::err_class_t FB_ERR_CLASS,
   input wire logic ERROR_IS_SAFE_TORQUE_CUT,
   input wire logic SUSPEND_ACTIVE,
   input wire logic PHASE_SHORT,
   input wire logic NETWORK_RUN_LAMP,
   input wire logic NETWORK_ERROR_LAMP,
   input wire logic DECIMAL_POINT,
   input wire logic DEMAND_RAMP_ZERO,
   input wire logic DRIVE_TRIPPED
);
   import status_ind_pkg::*;
   default clocking dc @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   // Three or four samples cover the two-cycle lamp restart
   startup_dark_a: assert property (!STARTUP_DONE [*3] |-> !NETWORK_RUN_LAMP)
      else $error("run lamp lit before startup");
   run_off_a: assert property (
      (STARTUP_DONE && FB_STATE == `FB_INIT && !IDENTIFY_REQ) [*4] |-> !NETWORK_RUN_LAMP)
      else $error("run lamp lit in init");
   run_steady_a: assert property (
      (STARTUP_DONE && FB_STATE == `FB_OP && !IDENTIFY_REQ) [*4] |-> NETWORK_RUN_LAMP)
      else $error("run lamp dark in operational");
   err_off_a: assert property (
      (STARTUP_DONE && FB_ERR_CLASS == `ERRC_NONE) [*4] |-> !NETWORK_ERROR_LAMP)
      else $error("error lamp lit without error");
   trip_hold_a: assert property (DRIVE_TRIPPED |=> DRIVE_TRIPPED)
      else $error("trip released");
   trip_soon_a: assert property ($rose(PHASE_SHORT) |-> ##[1:5] DRIVE_TRIPPED)
      else $error("phase short did not trip");
   suspend_ramp_a: assert property (SUSPEND_ACTIVE |=> DEMAND_RAMP_ZERO)
      else $error("suspend without ramp to zero");
   ramp_cause_a: assert property (
      DEMAND_RAMP_ZERO |-> $past(SUSPEND_ACTIVE) || DRIVE_TRIPPED)
      else $error("ramp to zero without cause");
   dp_quiet_a: assert property (!ERROR_IS_SAFE_TORQUE_CUT [*2] |-> !DECIMAL_POINT)
      else $error("decimal point without safety error");
endmodule : status_ind_checker

bind drive_status_indicator_logic status_ind_checker status_ind_checker_i
(
   .CLK(CLK), .RST_N(RST_N), .STARTUP_DONE(STARTUP_DONE), .FB_STATE(FB_STATE),
   .IDENTIFY_REQ(IDENTIFY_REQ), .FB_ERR_CLASS(FB_ERR_CLASS),
   .ERROR_IS_SAFE_TORQUE_CUT(ERROR_IS_SAFE_TORQUE_CUT), .SUSPEND_ACTIVE(SUSPEND_ACTIVE),
   .PHASE_SHORT(PHASE_SHORT), .NETWORK_RUN_LAMP(NETWORK_RUN_LAMP),
   .NETWORK_ERROR_LAMP(NETWORK_ERROR_LAMP), .DECIMAL_POINT(DECIMAL_POINT),
   .DEMAND_RAMP_ZERO(DEMAND_RAMP_ZERO), .DRIVE_TRIPPED(DRIVE_TRIPPED)
);

// ---- verification/fieldbus_slave_model.sv ----
/*
 Fieldbus slave controller stand-in: state, error class and identify level.
 Assumes bench requests; a change lands lag plus one clocks later.
*/
`timescale 1ns/10ps
`include "status_ind_map.svh"
module fieldbus_slave_model
(
   input wire logic clk,
   input wire logic [1:0] lag,
   input wire status_ind_pkg::fb_state_t want_state,
   input wire status_ind_pkg::err_class_t want_err,
   input wire logic want_ident,
   output status_ind_pkg::fb_state_t fb_state,
   output status_ind_pkg::err_class_t fb_err,
   output logic ident
);
   import status_ind_pkg::*;
   logic [1:0] wait_cnt = 2'h0;
   // Powers up in init with no error
   initial
   begin
      fb_state = `FB_INIT;
      fb_err = `ERRC_NONE;
      ident = 1'b0;
   end
   always @(posedge clk)
   begin
      if ({want_state, want_err, want_ident} === {fb_state, fb_err, ident})
         wait_cnt <= 2'h0;
      else if (wait_cnt == lag)
      begin
         fb_state <= want_state;
         fb_err <= want_err;
         ident <= want_ident;
         wait_cnt <= 2'h0;
      end
      else
         wait_cnt <= wait_cnt + 2'h1;
   end
endmodule : fieldbus_slave_model

// ---- verification/tb_drive_status_indicator_logic.sv ----
/*
 Self-checking bench for the drive status indicator with a fieldbus model.
 Assumes shortened lamp and digit counts and a 25 MHz clock.
*/
`timescale 1ns/10ps
`include "status_ind_map.svh"
module tb_drive_status_indicator_logic;
   import status_ind_pkg::*;
   typedef struct {int kind; logic [15:0] mask; logic [15:0] val;} note_t;
   localparam int bl = 4;
   localparam int fon = 3;
   localparam int foff = 8;
   localparam int dg = 5;
   localparam int rper[6] = '{2*bl, 2*bl, 2*bl, fon+foff, 2*bl, 5*fon+foff};
   localparam int rhi[6] = '{0, bl, 0, fon, 2*bl, 3*fon};
   localparam int eper[4] = '{2*bl, 2*bl, fon+foff, 3*fon+foff};
   localparam int ehi[4] = '{0, bl, fon, 2*fon};
   localparam fb_state_t rst[6] = '{`FB_INIT, `FB_PREOP, `FB_BOOT, `FB_SAFEOP, `FB_OP, `FB_OP};
   localparam seg_t mseg[12] = '{`SEG_C, `SEG_D, `SEG_F, `SEG_FOLLOW, `SEG_HOME, `SEG_INC,
      `SEG_J, `SEG_O, `SEG_P, `SEG_TORQ, `SEG_VEL, `SEG_SPL};
   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   logic STARTUP_DONE = 1'b0, FW_LOADING = 1'b1, ERROR_ACTIVE = 1'b0;
   logic [3:0] FW_STAGE = 4'h0;
   logic [19:0] ERROR_CODE = 20'h0;
   logic ERROR_IS_SAFE_TORQUE_CUT = 1'b0, SAFE_TORQUE_CUT_A = 1'b1, SAFE_TORQUE_CUT_B = 1'b1;
   logic DRIVE_ENABLED = 1'b0, SUSPEND_ACTIVE = 1'b0, STOP_ACTIVE = 1'b0;
   logic HOLD_TO_ANALOG = 1'b0, USER_SYMBOL_WRITE = 1'b0, USER_SYMBOL_CLEAR = 1'b0;
   logic PHASE_SHORT = 1'b0;
   motion_t MOTION_TYPE = `MOT_NONE;
   seg_t USER_SYMBOL = 7'h00;
   fb_state_t FB_STATE, want_state = `FB_INIT;
   err_class_t FB_ERR_CLASS, want_err = `ERRC_NONE;
   logic IDENTIFY_REQ, want_ident = 1'b0;
   logic [1:0] lag = 2'h0;
   logic NETWORK_RUN_LAMP, NETWORK_ERROR_LAMP, DECIMAL_POINT, DEMAND_RAMP_ZERO, DRIVE_TRIPPED;
   seg_t SEGMENTS;
   logic [31:0] seed = 32'h3808;
   logic [7:0] run_cnt, err_cnt;
   logic counting = 1'b0;
   note_t notes[$];
   event look;
   int failures = 0;
   int compares = 0;

   always #20 CLK = ~CLK;

   drive_status_indicator_logic #(.BLINK_CYCLES(32'h4), .FLASH_ON_CYCLES(32'h3),
      .FLASH_OFF_CYCLES(32'h8), .DIGIT_CYCLES(32'h5)) drive_status_indicator_logic_i
   (
      .CLK(CLK), .RST_N(RST_N), .STARTUP_DONE(STARTUP_DONE), .FW_LOADING(FW_LOADING),
      .FW_STAGE(FW_STAGE), .FB_STATE(FB_STATE), .IDENTIFY_REQ(IDENTIFY_REQ),
      .FB_ERR_CLASS(FB_ERR_CLASS), .ERROR_ACTIVE(ERROR_ACTIVE), .ERROR_CODE(ERROR_CODE),
      .ERROR_IS_SAFE_TORQUE_CUT(ERROR_IS_SAFE_TORQUE_CUT), .SAFE_TORQUE_CUT_A(SAFE_TORQUE_CUT_A),
      .SAFE_TORQUE_CUT_B(SAFE_TORQUE_CUT_B), .DRIVE_ENABLED(DRIVE_ENABLED),
      .SUSPEND_ACTIVE(SUSPEND_ACTIVE), .STOP_ACTIVE(STOP_ACTIVE), .HOLD_TO_ANALOG(HOLD_TO_ANALOG),
      .MOTION_TYPE(MOTION_TYPE), .USER_SYMBOL_WRITE(USER_SYMBOL_WRITE), .USER_SYMBOL(USER_SYMBOL),
      .USER_SYMBOL_CLEAR(USER_SYMBOL_CLEAR), .PHASE_SHORT(PHASE_SHORT),
      .NETWORK_RUN_LAMP(NETWORK_RUN_LAMP), .NETWORK_ERROR_LAMP(NETWORK_ERROR_LAMP),
      .SEGMENTS(SEGMENTS), .DECIMAL_POINT(DECIMAL_POINT), .DEMAND_RAMP_ZERO(DEMAND_RAMP_ZERO),
      .DRIVE_TRIPPED(DRIVE_TRIPPED)
   );
   fieldbus_slave_model fieldbus_slave_model_i
   (
      .clk(CLK), .lag(lag), .want_state(want_state), .want_err(want_err),
      .want_ident(want_ident), .fb_state(FB_STATE), .fb_err(FB_ERR_CLASS), .ident(IDENTIFY_REQ)
   );

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift

   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
   endtask : tick

   task automatic check(input int kind, input logic [15:0] mask, input logic [15:0] val);
      notes.push_back('{kind, mask, val});
      #5;
      -> look;
      tick(1);
   endtask : check

   task automatic see(input seg_t s, input logic dp);
      check(0, 16'h03FC, {6'h0, s, dp, 2'h0});
   endtask : see

   task automatic show(input seg_t s);
      tick(6);
      see(s, 1'b0);
   endtask : show

   // Window of both periods multiplied holds whole cycles of each lamp
   task automatic lamps(input int rs, input int es);
      want_state <= rst[rs];
      want_ident <= (rs == 5);
      want_err <= 2'(es);
      tick(12);
      run_cnt = 8'h0;
      err_cnt = 8'h0;
      counting <= 1'b1;
      tick(rper[rs] * eper[es]);
      counting <= 1'b0;
      check(1, 16'hFFFF, {8'(rhi[rs] * eper[es]), 8'(ehi[es] * rper[rs])});
   endtask : lamps

   always @(posedge CLK)
   begin
      if (counting)
      begin
         run_cnt <= run_cnt + {7'h0, NETWORK_RUN_LAMP};
         err_cnt <= err_cnt + {7'h0, NETWORK_ERROR_LAMP};
      end
   end

   always @(look)
   begin
      note_t n;
      logic [15:0] obs;
      n = notes.pop_front();
      case (n.kind)
         0: obs = {4'h0, NETWORK_RUN_LAMP, NETWORK_ERROR_LAMP, SEGMENTS, DECIMAL_POINT,
            DEMAND_RAMP_ZERO, DRIVE_TRIPPED} & n.mask;
         1: obs = {run_cnt, err_cnt};
         default: obs = {15'h0, SEGMENTS[6] === 1'b0 && $onehot(SEGMENTS[5:0])};
      endcase
      compares++;
      if (obs !== n.val)
      begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, obs, n.val);
      end
   end

   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : give_verdict

   initial
   begin
      #400000;
      failures++;
      give_verdict();
   end

   initial
   begin
      int k;
      seg_t last;
      seg_t dig[5];
      tick(20);
      check(0, 16'h0C07, 16'h0);
      RST_N <= 1'b1;
      tick(3);
      repeat (6) check(2, 16'h1, 16'h1);
      FW_LOADING <= 1'b0;
      FW_STAGE <= 4'h5;
      show(`SEG_5);
      want_state <= `FB_OP;
      want_err <= `ERRC_WDOG;
      tick(12);
      check(0, 16'h0C00, 16'h0);
      STARTUP_DONE <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         seed = xorshift(seed);
         lag <= seed[1:0];
         lamps(i, i % 4);
      end
      show(`SEG_DASH);
      SAFE_TORQUE_CUT_B <= 1'b0;
      show(`SEG_DASH_CUT);
      SAFE_TORQUE_CUT_B <= 1'b1;
      DRIVE_ENABLED <= 1'b1;
      show(`SEG_8);
      seed = xorshift(seed);
      for (int i = 0; i < 12; i++)
      begin
         k = (i + int'(seed[3:0])) % 12;
         MOTION_TYPE <= 4'(k + 1);
         show(mseg[k]);
      end
      last = mseg[k];
      HOLD_TO_ANALOG <= 1'b1;
      show(`SEG_HOLD);
      STOP_ACTIVE <= 1'b1;
      show(`SEG_5);
      SUSPEND_ACTIVE <= 1'b1;
      tick(6);
      check(0, 16'h03FE, {6'h0, `SEG_UNDER, 3'h2});
      {SUSPEND_ACTIVE, STOP_ACTIVE, HOLD_TO_ANALOG} <= 3'h0;
      USER_SYMBOL <= seed[10:4];
      USER_SYMBOL_WRITE <= 1'b1;
      tick(1);
      USER_SYMBOL_WRITE <= 1'b0;
      show(seed[10:4]);
      USER_SYMBOL_CLEAR <= 1'b1;
      tick(1);
      USER_SYMBOL_CLEAR <= 1'b0;
      show(last);
      for (int i = 0; i < 5; i++)
      begin
         dig[i] = seed[i + 11] ? `SEG_5 : `SEG_8;
         ERROR_CODE[4*i +: 4] <= seed[i + 11] ? 4'h5 : 4'h8;
      end
      ERROR_IS_SAFE_TORQUE_CUT <= 1'b1;
      ERROR_ACTIVE <= 1'b1;
      // Looks just after each edge so the display has settled
      for (int i = 0; i < 40 && SEGMENTS !== `SEG_E; i++)
      begin
         tick(1);
         #1;
      end
      tick(2);
      see(`SEG_E, 1'b1);
      for (int i = 4; i >= 0; i--)
      begin
         tick(dg - 1);
         see(dig[i], 1'b1);
      end
      {ERROR_ACTIVE, ERROR_IS_SAFE_TORQUE_CUT} <= 2'h0;
      tick(40);
      show(last);
      PHASE_SHORT <= 1'b1;
      tick(4);
      PHASE_SHORT <= 1'b0;
      tick(30);
      check(0, 16'h0003, 16'h0003);
      RST_N <= 1'b0;
      tick(3);
      RST_N <= 1'b1;
      tick(2);
      check(0, 16'h0003, 16'h0);
      give_verdict();
   end
endmodule : tb_drive_status_indicator_logic
